// >>> rtl/ccss_top.sv
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module ccss_top #(
   parameter logic [4:0] AVAIL = ccss_pkg::AVAIL_RESET
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cmp_out_i,
   output ccss_pkg::ccss_route_s route_o,
   output logic irq_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // out_q is the stage behind the synchroniser; comparing it with sync2_q
   // gives the edge without a separate delay flop
   logic sync1_q, sync2_q, out_q, out_d;
   logic evt_q, evt_d;
   logic ref_q, ref_d;
   logic [1:0] ch_q, ch_d;
   logic irq_stat_q, irq_stat_d;
   logic irq_en_q, irq_en_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   ccss_pkg::ccss_route_s route_q, route_d;
   logic wr_commit, req, event_hit;
   logic [15:0] ctrl_rd, stat_rd;

   // ---------------------------------------------------------------
   // register read views
   // ---------------------------------------------------------------

   // control word; bits 5, 3:2 and all others not listed stay zero
   function automatic logic [15:0] ctrl_view(input logic evt,
                                             input logic outb,
                                             input logic rsel,
                                             input logic [1:0] ch);
      logic [15:0] v;
      v = 16'h0000;
      v[ccss_pkg::CTRL_EVT_BIT] = evt;
      v[ccss_pkg::CTRL_OUT_BIT] = outb;
      v[ccss_pkg::CTRL_REF_BIT] = rsel;
      v[ccss_pkg::CTRL_CH_LSB +: 2] = ch;
      return v;
   endfunction

   // shared status is built from the very same flops, so it cannot drift
   always_comb begin
      ctrl_rd = ctrl_view(evt_q, out_q, ref_q, ch_q);
      stat_rd = 16'h0000;
      stat_rd[ccss_pkg::STAT_EVT_BIT] = ctrl_rd[ccss_pkg::CTRL_EVT_BIT];
      stat_rd[ccss_pkg::STAT_OUT_BIT] = ctrl_rd[ccss_pkg::CTRL_OUT_BIT];
   end

   // ---------------------------------------------------------------
   // comparator output synchroniser and event detect
   // ---------------------------------------------------------------

   // the analog output is asynchronous; only sync2 feeds logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= cmp_out_i;
         sync2_q <= sync1_q;
      end
   end

   // an event is any change of the synchronised output
   // both edges count; a software clear landing with an edge loses to it
   assign event_hit = sync2_q ^ out_q;

   // ---------------------------------------------------------------
   // wishbone classic slave
   // ---------------------------------------------------------------

   // ack one cycle after the request, dropped the cycle after; a write
   // commits on the edge where the master sees ack, never earlier
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_commit = req & wb_we_i & ack_q;

   always_comb begin
      ack_d = req & ~ack_q;
      rdat_d = rdat_q;
      if (ack_d) begin
         rdat_d = 32'h0000_0000; // unmapped and write cycles read zero
         if (!wb_we_i) begin
            unique case (wb_adr_i)
               ccss_pkg::ADDR_CTRL: rdat_d = {16'h0000, ctrl_rd};
               ccss_pkg::ADDR_STAT: rdat_d = {16'h0000, stat_rd};
               ccss_pkg::ADDR_IRQ_STAT: rdat_d[ccss_pkg::IRQ_EVT_BIT] =
                  irq_stat_q;
               ccss_pkg::ADDR_IRQ_EN: rdat_d[ccss_pkg::IRQ_EVT_BIT] =
                  irq_en_q;
               default: rdat_d = 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // control, flag and interrupt registers
   // ---------------------------------------------------------------

   // software may only clear the event flag; an event in the same
   // cycle as the clear wins, so no event is ever lost
   always_comb begin
      out_d = sync2_q;
      evt_d = evt_q;
      ref_d = ref_q;
      ch_d = ch_q;
      irq_stat_d = irq_stat_q;
      irq_en_d = irq_en_q;
      if (wr_commit) begin
         unique case (wb_adr_i)
            ccss_pkg::ADDR_CTRL: begin
               if (wb_sel_i[0]) begin
                  ref_d = wb_dat_i[ccss_pkg::CTRL_REF_BIT];
                  ch_d = wb_dat_i[ccss_pkg::CTRL_CH_LSB +: 2];
               end
               if (wb_sel_i[1] && !wb_dat_i[ccss_pkg::CTRL_EVT_BIT]) begin
                  evt_d = 1'b0;
               end
            end
            // mirrors have no storage of their own; writes fall away
            ccss_pkg::ADDR_STAT: evt_d = evt_q;
            ccss_pkg::ADDR_IRQ_EN: begin
               if (wb_sel_i[0]) begin
                  irq_en_d = wb_dat_i[ccss_pkg::IRQ_EVT_BIT];
               end
            end
            ccss_pkg::ADDR_IRQ_CLR: begin
               if (wb_sel_i[0] && wb_dat_i[ccss_pkg::IRQ_EVT_BIT]) begin
                  irq_stat_d = 1'b0;
               end
            end
            default: evt_d = evt_q;
         endcase
      end
      if (event_hit) begin
         evt_d = 1'b1;
         irq_stat_d = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // input routing
   // ---------------------------------------------------------------

   // registered so the analog switch select never glitches mid-cycle
   // the internal reference is always present, so only the external
   // pins and amplifier taps can fall back to ground
   always_comb begin
      if (ref_q) begin
         route_d.pos = ccss_pkg::CCSS_POS_REF;
      end else if (AVAIL[0]) begin
         route_d.pos = ccss_pkg::CCSS_POS_EXT;
      end else begin
         route_d.pos = ccss_pkg::CCSS_POS_GND;
      end
      unique case (ch_q)
         ccss_pkg::CH_AMP3: route_d.neg = ccss_pkg::CCSS_NEG_AMP3;
         ccss_pkg::CH_AMP2: route_d.neg = ccss_pkg::CCSS_NEG_AMP2;
         ccss_pkg::CH_AMP1: route_d.neg = ccss_pkg::CCSS_NEG_AMP1;
         ccss_pkg::CH_EXT: route_d.neg = ccss_pkg::CCSS_NEG_EXT;
      endcase
      // bits 1..4 of the mask follow the channel code order
      if (!AVAIL[ch_q + 3'h1]) begin
         route_d.neg = ccss_pkg::CCSS_NEG_GND;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // one register bank for all but the synchroniser flops; every next value comes from the blocks above, so
   // reset and hold behaviour live in a single place
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
         evt_q <= 1'b0;
         ref_q <= ccss_pkg::REF_RESET;
         ch_q <= ccss_pkg::CH_RESET;
         irq_stat_q <= 1'b0;
         irq_en_q <= ccss_pkg::IRQ_EN_RESET;
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         route_q <= '{pos: ccss_pkg::CCSS_POS_EXT,
                      neg: ccss_pkg::CCSS_NEG_EXT};
      end else begin
         out_q <= out_d;
         evt_q <= evt_d;
         ref_q <= ref_d;
         ch_q <= ch_d;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= irq_en_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         route_q <= route_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // ack and read data leave straight from flops; irq is the and of two
   // flops, so it carries no combinational glitch
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign route_o = route_q;
   assign irq_o = irq_stat_q & irq_en_q; // level, high while pending and enabled

endmodule

// >>> rtl/ccss_pkg.sv
// Notes on behaviour
// - The status event bit always equals the control event flag at bit 9.
// - The status output bit always equals the control output bit at bit 8.
// - Bit 4 high: positive input from internal reference; low: external pin.
// - Bits 1:0 pick the negative input: 11 amp3, 10 amp2, 01 amp1, 00 pin.
// - Control bits 5 and 3:2 are unimplemented: read zero, writes ignored.
// - A selected input that is not bonded out is tied to ground, except in reset, where both inputs route to their external pins.
// - The event flag reads one after a comparator event, zero if none yet.
package ccss_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00; // comparator_four_control
   localparam logic [7:0] ADDR_STAT = 8'h04; // comparator_shared_status
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08; // sticky, read-only
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10; // write-one-to-clear

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_EVT_BIT = 9;
   localparam int CTRL_OUT_BIT = 8;
   localparam int CTRL_REF_BIT = 4;
   localparam int CTRL_CH_LSB = 0;
   localparam int STAT_EVT_BIT = 11;
   localparam int STAT_OUT_BIT = 3;
   localparam int IRQ_EVT_BIT = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] CH_RESET = 2'h0;
   localparam logic REF_RESET = 1'b0;
   localparam logic IRQ_EN_RESET = 1'b0;
   // availability mask: [0] ext pos, [1] ext neg, [2] amp1, [3] amp2,
   // [4] amp3; all bonded out unless a package option says otherwise
   localparam logic [4:0] AVAIL_RESET = 5'h1F;

   // ---------------------------------------------------------------
   // channel codes and routing
   // ---------------------------------------------------------------
   localparam logic [1:0] CH_EXT = 2'h0;
   localparam logic [1:0] CH_AMP1 = 2'h1;
   localparam logic [1:0] CH_AMP2 = 2'h2;
   localparam logic [1:0] CH_AMP3 = 2'h3;

   typedef enum logic [1:0] {
      CCSS_POS_EXT,
      CCSS_POS_REF,
      CCSS_POS_GND
   } ccss_pos_e;

   typedef enum logic [2:0] {
      CCSS_NEG_EXT,
      CCSS_NEG_AMP1,
      CCSS_NEG_AMP2,
      CCSS_NEG_AMP3,
      CCSS_NEG_GND
   } ccss_neg_e;

   typedef struct packed {
      ccss_pos_e pos;
      ccss_neg_e neg;
   } ccss_route_s;

endpackage

// >>> tb/ccss_sva.sv
`timescale 1ns/1ps
module ccss_sva #(
   parameter logic [4:0] AVAIL = 5'h1F
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic cmp_out_i,
   input wire ccss_pkg::ccss_route_s route_o,
   input wire logic irq_o
);
   logic [2:0] stab_q, stab_d;
   logic prev_q, en_q, en_d;
   ccss_pkg::ccss_route_s rexp_q, rexp_d;
   wire wr = wb_ack_o && wb_we_i;
   wire rd = wb_ack_o && !wb_we_i;
   wire ctl_wr = wr && wb_adr_i == ccss_pkg::ADDR_CTRL && wb_sel_i[0];
   // pin stability count lets checks skip events still in the synchroniser
   always_comb begin
      stab_d = (cmp_out_i != prev_q) ? 3'h0 : stab_q + {2'h0, stab_q != 3'h7};
      en_d = (wr && wb_adr_i == ccss_pkg::ADDR_IRQ_EN && wb_sel_i[0]) ?
         wb_dat_i[0] : en_q;
      rexp_d = rexp_q;
      if (ctl_wr) begin
         rexp_d.pos = wb_dat_i[4] ? ccss_pkg::CCSS_POS_REF :
            (AVAIL[0] ? ccss_pkg::CCSS_POS_EXT : ccss_pkg::CCSS_POS_GND);
         rexp_d.neg = AVAIL[3'(wb_dat_i[1:0]) + 3'h1] ?
            ccss_pkg::ccss_neg_e'({1'b0, wb_dat_i[1:0]}) :
            ccss_pkg::CCSS_NEG_GND;
      end
   end
   // helper registers
   always_ff @(posedge clk_i) begin
      prev_q <= cmp_out_i;
      stab_q <= rst_i ? 3'h0 : stab_d;
      en_q <= rst_i ? 1'b0 : en_d;
      rexp_q <= rexp_d;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   chk_ctrl_zero: assert property (
      rd && wb_adr_i == ccss_pkg::ADDR_CTRL |-> (wb_dat_o & 32'hFFFFFCEC) == 0)
      else $error("unimplemented control bits not zero");
   chk_route_pos: assert property (
      ctl_wr |-> ##2 route_o.pos == rexp_q.pos) else $error("positive route");
   chk_route_neg: assert property (
      ctl_wr |-> ##2 route_o.neg == rexp_q.neg) else $error("negative route");
   chk_out_ctrl: assert property (
      rd && wb_adr_i == ccss_pkg::ADDR_CTRL && stab_q == 3'h7
      |-> wb_dat_o[8] == cmp_out_i) else $error("output bit stale");
   chk_out_stat: assert property (
      rd && wb_adr_i == ccss_pkg::ADDR_STAT && stab_q == 3'h7
      |-> wb_dat_o[3] == cmp_out_i) else $error("status output bit stale");
   chk_irq_masked: assert property (!en_q |-> !irq_o)
      else $error("irq while disabled");
   chk_irq_clear: assert property (
      wr && wb_adr_i == ccss_pkg::ADDR_IRQ_CLR && wb_dat_i[0] && wb_sel_i[0]
      && stab_q == 3'h7 |=> !irq_o) else $error("irq survives clear");
endmodule

bind ccss_top ccss_sva #(.AVAIL(AVAIL)) u_ccss_sva (.clk_i, .rst_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_out_i,
   .route_o, .irq_o);

// >>> tb/ccss_top_bench.sv
`timescale 1ns/1ps
module ccss_top_bench;
   // ext pos, amp1 missing: exercises grounding on both inputs
   localparam logic [4:0] AV = 5'h1A;
   logic clk_i = 1'b0, rst_i = 1'b1, cmp_out_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, irq_o;
   ccss_pkg::ccss_route_s route_o, ex;
   int err_count = 0, total_checks = 0;
   always #2.5 clk_i = ~clk_i;
   ccss_top #(.AVAIL(AV)) u_ccss_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .cmp_out_i, .route_o, .irq_o);
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_route(input ccss_pkg::ccss_route_s got,
      input ccss_pkg::ccss_route_s exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: route %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_irq(input logic exp);
      total_checks++;
      if (irq_o !== exp) begin
         err_count++;
         $display("Error at %0t: irq %h expected %h", $time, irq_o, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one classic cycle; the idle edge before it keeps cyc low a cycle
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [3:0] s, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // every channel and reference choice, junk in the unused bits
   task automatic t_route;
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, ccss_pkg::ADDR_CTRL, 4'h3, {27'h1, i[2], 2'h3, i[1:0]});
         wb(1'b0, ccss_pkg::ADDR_CTRL, 4'h3, 32'h0);
         check(rd, {27'h0, i[2], 2'h0, i[1:0]});
         ex.pos = i[2] ? ccss_pkg::CCSS_POS_REF : ccss_pkg::CCSS_POS_GND;
         ex.neg = AV[i[1:0] + 1] ? ccss_pkg::ccss_neg_e'(i[2:0] & 3'h3) :
            ccss_pkg::CCSS_NEG_GND;
         check_route(route_o, ex);
      end
   endtask
   // event, mirror, read-only status, clear, mask and unmapped access
   task automatic t_event;
      wb(1'b1, ccss_pkg::ADDR_IRQ_EN, 4'h1, 32'h1);
      cmp_out_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      check_irq(1'b1);
      wb(1'b0, ccss_pkg::ADDR_STAT, 4'hF, 32'h0);
      check(rd, 32'h808);
      wb(1'b1, ccss_pkg::ADDR_STAT, 4'hF, 32'h0);
      wb(1'b0, ccss_pkg::ADDR_CTRL, 4'hF, 32'h0);
      check(rd, 32'h313);
      wb(1'b1, ccss_pkg::ADDR_CTRL, 4'h2, 32'h0);
      wb(1'b0, ccss_pkg::ADDR_STAT, 4'hF, 32'h0);
      check(rd, 32'h008);
      wb(1'b1, ccss_pkg::ADDR_IRQ_CLR, 4'h1, 32'h1);
      @(posedge clk_i);
      check_irq(1'b0);
      wb(1'b1, ccss_pkg::ADDR_IRQ_EN, 4'h1, 32'h0);
      cmp_out_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      check_irq(1'b0);
      wb(1'b0, ccss_pkg::ADDR_IRQ_STAT, 4'hF, 32'h0);
      check(rd, 32'h1);
      wb(1'b0, ccss_pkg::ADDR_CTRL, 4'hF, 32'h0);
      check(rd, 32'h213);
      wb(1'b0, 8'h20, 4'hF, 32'h0);
      check(rd, 32'h0);
   endtask
   // defaults after reset; with pulse set, a reset in mid-run first
   task automatic t_reset(input logic pulse);
      if (pulse) begin
         rst_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         rst_i <= 1'b0;
      end
      wb(1'b0, ccss_pkg::ADDR_CTRL, 4'hF, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, ccss_pkg::ADDR_IRQ_STAT, 4'hF, 32'h0);
      check(rd, 32'h0);
      check_irq(1'b0);
      ex.pos = ccss_pkg::CCSS_POS_GND;
      ex.neg = ccss_pkg::CCSS_NEG_EXT;
      check_route(route_o, ex);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset(1'b0);
      t_route;
      t_event;
      t_reset(1'b1);
      tally_and_finish;
   end
   // watchdog: the run needs well under a thousand cycles
   initial begin
      #20000;
      err_count++;
      tally_and_finish;
   end
endmodule
